// ==== include/ufc_pkg.sv ====
// Package for the serial channel format and interrupt control block.
// Assumes a 200 MHz system clock and an Avalon-MM register slave.
package ufc_pkg;

  // ****************************************************************
  // Register map (word index, byte address is four times the index)
  // ****************************************************************
  localparam logic [2:0] UFC_OFS_LFC = 3'h0;  // line_format_control
  localparam logic [2:0] UFC_OFS_FCTL = 3'h1;  // fifo_control / divisor
  localparam logic [2:0] UFC_OFS_IST = 3'h2;  // interrupt_status / enhanced

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] UFC_LFC_RST = 8'h00;
  localparam logic [7:0] UFC_ENH_RST = 8'h00;
  localparam logic [15:0] UFC_DIV_RST = 16'h0000;
  localparam logic [4:0] UFC_TRIG_RST = 5'h01;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int UFC_LFC_DLAB = 7;
  localparam int UFC_LFC_BRK = 6;
  localparam int UFC_LFC_PEN = 3;
  localparam int UFC_LFC_STOP = 2;
  localparam int UFC_ENH_BIT = 4;
  localparam int UFC_FCTL_EN = 0;
  localparam int UFC_FCTL_RXCLR = 1;
  localparam int UFC_FCTL_TRIG = 6;

  // ****************************************************************
  // Receive trigger levels
  // ****************************************************************
  localparam logic [4:0] UFC_TRIG_L0 = 5'h01;
  localparam logic [4:0] UFC_TRIG_L1 = 5'h04;
  localparam logic [4:0] UFC_TRIG_L2 = 5'h08;
  localparam logic [4:0] UFC_TRIG_L3 = 5'h0e;

  // ****************************************************************
  // Interrupt sources (index order is priority order) and codes
  // ****************************************************************
  localparam int UFC_NSRC = 7;
  localparam logic [2:0] UFC_SRC_LS = 3'h0;
  localparam logic [2:0] UFC_SRC_RXDAT = 3'h1;
  localparam logic [2:0] UFC_SRC_RXTO = 3'h2;
  localparam logic [2:0] UFC_SRC_THR = 3'h3;
  localparam logic [2:0] UFC_SRC_MODEM = 3'h4;
  localparam logic [2:0] UFC_SRC_XOFF = 3'h5;
  localparam logic [2:0] UFC_SRC_FLOW = 3'h6;
  localparam logic [5:0] UFC_CODE_LS = 6'h06;
  localparam logic [5:0] UFC_CODE_RXDAT = 6'h04;
  localparam logic [5:0] UFC_CODE_RXTO = 6'h0c;
  localparam logic [5:0] UFC_CODE_THR = 6'h02;
  localparam logic [5:0] UFC_CODE_MODEM = 6'h00;
  localparam logic [5:0] UFC_CODE_XOFF = 6'h10;
  localparam logic [5:0] UFC_CODE_FLOW = 6'h20;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    UFC_PAR_NONE = 3'h0,
    UFC_PAR_ODD = 3'h1,
    UFC_PAR_EVEN = 3'h2,
    UFC_PAR_ONE = 3'h3,
    UFC_PAR_ZERO = 3'h4
  } ufc_par_t;

  typedef enum logic [1:0] {
    UFC_BUS_IDLE = 2'b01,
    UFC_BUS_ACK = 2'b10
  } ufc_bus_t;

endpackage

// ==== verilog/ufc_flag.sv ====
// Sticky event flag: set wins over clear in the same cycle.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module ufc_flag
  import ufc_pkg::*;
(
  input wire logic sys_clk,  // System clock
  input wire logic rstn,     // Asynchronous reset, active low
  input wire logic set,      // Event pulse
  input wire logic clr,      // Clear pulse
  output logic q             // Flag level
);

  typedef struct packed {
    logic q;
  } ufc_flag_st_t;

  ufc_flag_st_t st_ff;
  ufc_flag_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (set) begin
      nxt_st.q = 1'b1;
    end else if (clr) begin
      nxt_st.q = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.q;

endmodule // ufc_flag

// ==== verilog/ufc_prio.sv ====
// Fixed priority picker: lowest index that is pending wins.
// Assumes a request vector from logic on the same clock.
`timescale 1ns/1ps
module ufc_prio
  import ufc_pkg::*;
#(
  parameter int N = 7
) (
  input wire logic [N-1:0] pend,  // Pending requests
  output logic [2:0] idx,         // Winning index
  output logic any                // Any request pending
);

  typedef struct packed {
    logic [2:0] idx;
    logic any;
  } ufc_prio_st_t;

  ufc_prio_st_t res;

  always_comb begin
    res = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend[i]) begin
        res.idx = i[2:0];
        res.any = 1'b1;
      end
    end
  end

  assign idx = res.idx;
  assign any = res.any;

endmodule // ufc_prio

// ==== verilog/ufc_ctrl.sv ====
// Format, FIFO control and prioritised interrupt status of one channel.
// Assumes an Avalon-MM master on sys_clk and event inputs that come
// from the channel's own logic on the same clock.
//
// Notes on behaviour
// - FIFO control bit 1 pulses a receive FIFO clear, then reads zero.
// - FIFO enable bit turns both FIFOs off at zero, on at one.
// - Other FIFO control bits are written only when enable is also one.
// - Trigger field picks 1, 4, 8 or 14 characters.
// - Status read returns code of the reported source, highest pending when picked.
// - Reported source stays until serviced; higher and lower ones wait.
// - Line status source reads 000110.
// - Data ready reads 000100, receive timeout reads 001100.
// - Holding empty reads 000010, modem change reads 000000.
// - Xoff match reads 010000 and stays until Xon arrives.
// - Status bits 5 and 4 only active with enhanced enable.
// - Flow-control change reads 100000, lowest priority.
// - Status bits 7 and 6 follow the FIFO enable.
// - Status bit 0 low when pending, high when idle and at reset.
// - Line bit 7 redirects accesses to divisor and enhanced register.
// - Line bit 6 holds the transmit output low as a break.
// - Line bits 5 to 3 select parity for both directions.
// - Line bit 2 selects stop length with the character length.
// - Line bits 1 and 0 select the character length.
// - Parity: bit 3 off none; else 01 odd, 11 even, 10 one, 00 zero.
// - Stop select one gives 1.5 stops at five bits, else two.
// - Length codes 00 to 11 give five to eight data bits.
`timescale 1ns/1ps
module ufc_ctrl
  import ufc_pkg::*;
(
  input wire logic sys_clk,              // System clock, 200 MHz
  input wire logic rstn,                 // Asynchronous reset, active low
  input wire logic [2:0] avs_address,    // Word index
  input wire logic avs_read,             // Read request
  input wire logic avs_write,            // Write request
  input wire logic [3:0] avs_byteenable, // Byte lanes of a write
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata,      // Read data
  output logic avs_waitrequest,          // Stall of the request
  input wire logic ls_err,               // Line status error pending
  input wire logic [4:0] rx_count,       // Characters in receive FIFO
  input wire logic rx_timeout,           // Receive timeout pending
  input wire logic thr_empty_set,        // Holding register went empty
  input wire logic thr_load,             // Holding register written
  input wire logic modem_chg,            // Modem status change pending
  input wire logic xoff_match,           // Xoff or special char seen
  input wire logic xon_match,            // Xon character seen
  input wire logic flow_chg,             // CTS or RTS changed
  input wire logic tx_in,                // Serial data from shifter
  output logic tx_out,                   // Serial line output
  output logic fifo_enable,              // Both FIFOs enabled
  output logic rx_fifo_clear,            // One-cycle receive FIFO clear
  output logic [4:0] rx_trigger,         // Receive trigger level
  output logic dlab,                     // Divisor access selected
  output logic [15:0] divisor,           // Baud divisor latch
  output logic enh_enable,               // Enhanced features enabled
  output ufc_par_t parity_mode,          // Parity for both directions
  output logic [3:0] data_bits,          // Data bits per character
  output logic [2:0] stop_halves,        // Stop length in half bits
  output logic [7:0] int_status          // Current status byte
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    ufc_bus_t bus;
    logic [31:0] rdata;
    logic [7:0] lfc;
    logic fen;
    logic [4:0] trig;
    logic rxclr;
    logic [7:0] enh;
    logic [15:0] div;
    logic [2:0] cur;
    logic vld;
    logic txo;
  } ufc_st_t;

  ufc_st_t st_ff;
  ufc_st_t nxt_st;

  logic [UFC_NSRC-1:0] pend;
  logic [2:0] top;
  logic top_any;
  logic thr_q;
  logic xoff_q;
  logic thr_rd_clr;
  logic rx_ready;
  logic req;
  logic acc;
  logic wr_fctl;
  logic [5:0] code;
  logic [7:0] ist_v;

  // ****************************************************************
  // Interrupt sources
  // ****************************************************************
  ufc_flag u_thr (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .set(thr_empty_set),
    .clr(thr_load | thr_rd_clr),
    .q(thr_q)
  );

  ufc_flag u_xoff (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .set(xoff_match),
    .clr(xon_match),
    .q(xoff_q)
  );

  always_comb begin
    if (st_ff.fen) begin
      rx_ready = rx_count >= st_ff.trig;
    end else begin
      rx_ready = rx_count != 5'h00;
    end
    pend = '0;
    pend[UFC_SRC_LS] = ls_err;
    pend[UFC_SRC_RXDAT] = rx_ready;
    pend[UFC_SRC_RXTO] = rx_timeout;
    pend[UFC_SRC_THR] = thr_q;
    pend[UFC_SRC_MODEM] = modem_chg;
    pend[UFC_SRC_XOFF] = xoff_q & st_ff.enh[UFC_ENH_BIT];
    pend[UFC_SRC_FLOW] = flow_chg & st_ff.enh[UFC_ENH_BIT];
  end

  ufc_prio #(
    .N(UFC_NSRC)
  ) u_prio (
    .pend(pend),
    .idx(top),
    .any(top_any)
  );

  // ****************************************************************
  // Status byte
  // ****************************************************************
  always_comb begin
    case (st_ff.cur)
      UFC_SRC_LS: code = UFC_CODE_LS;
      UFC_SRC_RXDAT: code = UFC_CODE_RXDAT;
      UFC_SRC_RXTO: code = UFC_CODE_RXTO;
      UFC_SRC_THR: code = UFC_CODE_THR;
      UFC_SRC_MODEM: code = UFC_CODE_MODEM;
      UFC_SRC_XOFF: code = UFC_CODE_XOFF;
      UFC_SRC_FLOW: code = UFC_CODE_FLOW;
      default: code = UFC_CODE_MODEM;
    endcase
    if (!st_ff.vld) begin
      code = UFC_CODE_MODEM;
    end
    if (!st_ff.enh[UFC_ENH_BIT]) begin
      code[5:4] = 2'b00;
    end
    ist_v = {st_ff.fen, st_ff.fen, code[5:1], ~st_ff.vld};
  end

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign req = avs_read | avs_write;
  assign acc = req && (st_ff.bus == UFC_BUS_ACK);
  assign wr_fctl = acc && avs_write && avs_address == UFC_OFS_FCTL &&
                   !st_ff.lfc[UFC_LFC_DLAB] && avs_byteenable[0];
  // Clear only if the byte handed to the host showed holding empty
  assign thr_rd_clr = acc && avs_read && avs_address == UFC_OFS_IST &&
                      !st_ff.lfc[UFC_LFC_DLAB] &&
                      st_ff.rdata[5:0] == {UFC_CODE_THR[5:1], 1'b0};

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rxclr = 1'b0;
    nxt_st.txo = st_ff.lfc[UFC_LFC_BRK] ? 1'b0 : tx_in;
    // Hold the reported source until it is no longer pending
    if (!(st_ff.vld && pend[st_ff.cur])) begin
      nxt_st.vld = top_any;
      nxt_st.cur = top;
    end
    case (st_ff.bus)
      UFC_BUS_IDLE: begin
        if (req) begin
          nxt_st.bus = UFC_BUS_ACK;
          nxt_st.rdata = '0;
          case (avs_address)
            UFC_OFS_LFC: nxt_st.rdata[7:0] = st_ff.lfc;
            UFC_OFS_FCTL: begin
              if (st_ff.lfc[UFC_LFC_DLAB]) begin
                nxt_st.rdata[15:0] = st_ff.div;
              end
            end
            UFC_OFS_IST: begin
              if (st_ff.lfc[UFC_LFC_DLAB]) begin
                nxt_st.rdata[7:0] = st_ff.enh;
              end else begin
                nxt_st.rdata[7:0] = ist_v;
              end
            end
            default: nxt_st.rdata = '0;
          endcase
        end
      end
      UFC_BUS_ACK: begin
        nxt_st.bus = UFC_BUS_IDLE;
        if (acc && avs_write) begin
          case (avs_address)
            UFC_OFS_LFC: begin
              if (avs_byteenable[0]) begin
                nxt_st.lfc = avs_writedata[7:0];
              end
            end
            UFC_OFS_FCTL: begin
              if (st_ff.lfc[UFC_LFC_DLAB]) begin
                if (avs_byteenable[0]) begin
                  nxt_st.div[7:0] = avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                  nxt_st.div[15:8] = avs_writedata[15:8];
                end
              end
            end
            UFC_OFS_IST: begin
              if (st_ff.lfc[UFC_LFC_DLAB] && avs_byteenable[0]) begin
                nxt_st.enh = avs_writedata[7:0];
              end
            end
            default: nxt_st.bus = UFC_BUS_IDLE;
          endcase
        end
      end
      default: nxt_st.bus = UFC_BUS_IDLE;
    endcase
    if (wr_fctl) begin
      nxt_st.fen = avs_writedata[UFC_FCTL_EN];
      if (avs_writedata[UFC_FCTL_EN]) begin
        nxt_st.rxclr = avs_writedata[UFC_FCTL_RXCLR];
        case (avs_writedata[UFC_FCTL_TRIG +: 2])
          2'b00: nxt_st.trig = UFC_TRIG_L0;
          2'b01: nxt_st.trig = UFC_TRIG_L1;
          2'b10: nxt_st.trig = UFC_TRIG_L2;
          default: nxt_st.trig = UFC_TRIG_L3;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff.bus <= UFC_BUS_IDLE;
      st_ff.rdata <= '0;
      st_ff.lfc <= UFC_LFC_RST;
      st_ff.fen <= 1'b0;
      st_ff.trig <= UFC_TRIG_RST;
      st_ff.rxclr <= 1'b0;
      st_ff.enh <= UFC_ENH_RST;
      st_ff.div <= UFC_DIV_RST;
      st_ff.cur <= UFC_SRC_LS;
      st_ff.vld <= 1'b0;
      st_ff.txo <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign avs_waitrequest = req && (st_ff.bus != UFC_BUS_ACK);
  assign avs_readdata = st_ff.rdata;
  assign tx_out = st_ff.txo;
  assign fifo_enable = st_ff.fen;
  assign rx_fifo_clear = st_ff.rxclr;
  assign rx_trigger = st_ff.trig;
  assign dlab = st_ff.lfc[UFC_LFC_DLAB];
  assign divisor = st_ff.div;
  assign enh_enable = st_ff.enh[UFC_ENH_BIT];
  assign int_status = ist_v;
  assign data_bits = 4'h5 + {2'b00, st_ff.lfc[1:0]};

  always_comb begin
    if (!st_ff.lfc[UFC_LFC_STOP]) begin
      stop_halves = 3'h2;
    end else if (st_ff.lfc[1:0] == 2'b00) begin
      stop_halves = 3'h3;
    end else begin
      stop_halves = 3'h4;
    end
    if (!st_ff.lfc[UFC_LFC_PEN]) begin
      parity_mode = UFC_PAR_NONE;
    end else begin
      case (st_ff.lfc[5:4])
        2'b01: parity_mode = UFC_PAR_ODD;
        2'b11: parity_mode = UFC_PAR_EVEN;
        2'b10: parity_mode = UFC_PAR_ONE;
        default: parity_mode = UFC_PAR_ZERO;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_fctl_wr_off;
    wr_fctl && !avs_writedata[UFC_FCTL_EN];
  endsequence

  sequence s_fctl_wr_clr;
    wr_fctl && avs_writedata[UFC_FCTL_EN] && avs_writedata[UFC_FCTL_RXCLR];
  endsequence

  AST_RXCLR_PULSE: assert property (s_fctl_wr_clr |=> rx_fifo_clear ##1
    !rx_fifo_clear) else $error("rx clear not a single pulse");
  AST_FEN_OFF: assert property (s_fctl_wr_off |=> !fifo_enable &&
    ist_v[7:6] == 2'b00) else $error("fifo enable not cleared");
  AST_IGNORE: assert property (s_fctl_wr_off |=> $stable(rx_trigger) &&
    !rx_fifo_clear) else $error("fifo bits taken without enable");
  AST_TRIG14: assert property (wr_fctl && avs_writedata[7:6] == 2'b11 &&
    avs_writedata[0] |=> rx_trigger == 5'h0e)
    else $error("trigger level wrong");
  AST_PEND: assert property (top_any && !st_ff.vld |=> !ist_v[0])
    else $error("pending source not reported");
  AST_HOLD: assert property (st_ff.vld && pend[st_ff.cur] |=>
    $stable(st_ff.cur) && st_ff.vld) else $error("source changed");
  AST_LS: assert property (ls_err && !st_ff.vld |=> ist_v[5:0] ==
    6'h06) else $error("line status code wrong");
  AST_ENH: assert property (!st_ff.enh[UFC_ENH_BIT] |-> ist_v[5:4] ==
    2'b00) else $error("enhanced bits active");
  AST_BRK: assert property (st_ff.lfc[UFC_LFC_BRK] [*2] |-> !tx_out)
    else $error("break not held");
  AST_THR_CLR: assert property (thr_rd_clr && !thr_empty_set |=> !thr_q)
    else $error("holding empty not cleared by read");

endmodule // ufc_ctrl

// ==== bench/ufc_host.sv ====
// Host processor model: Avalon-MM master for the register slave.
// Assumes tasks are called from the bench, one access at a time.
`timescale 1ns/1ps
module ufc_host
  import ufc_pkg::*;
(
  input wire logic sys_clk,              // System clock
  input wire logic avs_waitrequest,      // Stall from the slave
  input wire logic [31:0] avs_readdata,  // Read data from the slave
  output logic [2:0] avs_address,        // Word index
  output logic avs_read,                 // Read request
  output logic avs_write,                // Write request
  output logic [3:0] avs_byteenable,     // Byte lanes
  output logic [31:0] avs_writedata      // Write data
);
  initial begin
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0;
  end

  // Hold the request until waitrequest is sampled low at a rising edge
  task automatic hold_req(output logic [31:0] d);
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
  endtask

  // Fifo control writes from the bench pass the enable bit as given; one write clears it
  task automatic wr(input logic [2:0] a, input logic [31:0] v,
                    input logic [3:0] be);
    logic [31:0] d;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= v;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    hold_req(d);
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    hold_req(d);
    avs_read <= 1'b0;
  endtask
endmodule // ufc_host

// ==== bench/ufc_ctrl_test.sv ====
// Self-checking bench for the format and interrupt control block.
// Assumes the host model drives the register bus.
`timescale 1ns/1ps
module ufc_ctrl_test
  import ufc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic ls_err = 0, rx_timeout = 0, thr_empty_set = 0, thr_load = 0;
  logic modem_chg = 0, xoff_match = 0, xon_match = 0, flow_chg = 0;
  logic tx_in = 1'b1;
  logic [4:0] rx_count = 5'h0;
  logic tx_out, fifo_enable, rx_fifo_clear, dlab, enh_enable;
  logic [4:0] rx_trigger;
  logic [15:0] divisor;
  ufc_par_t parity_mode;
  logic [3:0] data_bits;
  logic [2:0] stop_halves;
  logic [7:0] int_status, lfc;
  int err_total = 0;
  int cmp_count = 0;
  logic [5:0] code_tab [7] = '{UFC_CODE_LS, UFC_CODE_RXDAT, UFC_CODE_RXTO,
    UFC_CODE_THR, UFC_CODE_MODEM, UFC_CODE_XOFF, UFC_CODE_FLOW};
  logic [4:0] trig_tab [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};

  always #2.5 sys_clk = ~sys_clk;

  ufc_host host (.sys_clk(sys_clk), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata));

  ufc_ctrl uut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ls_err(ls_err), .rx_count(rx_count), .rx_timeout(rx_timeout),
    .thr_empty_set(thr_empty_set), .thr_load(thr_load),
    .modem_chg(modem_chg), .xoff_match(xoff_match), .xon_match(xon_match),
    .flow_chg(flow_chg), .tx_in(tx_in), .tx_out(tx_out),
    .fifo_enable(fifo_enable), .rx_fifo_clear(rx_fifo_clear),
    .rx_trigger(rx_trigger), .dlab(dlab), .divisor(divisor),
    .enh_enable(enh_enable), .parity_mode(parity_mode),
    .data_bits(data_bits), .stop_halves(stop_halves),
    .int_status(int_status));

  // ****************************************************************
  // Checking and expectations
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  function automatic logic [2:0] exp_par(input logic [7:0] l);
    if (!l[3]) return UFC_PAR_NONE;
    case (l[5:4])
      2'b01: return UFC_PAR_ODD;
      2'b11: return UFC_PAR_EVEN;
      2'b10: return UFC_PAR_ONE;
      default: return UFC_PAR_ZERO;
    endcase
  endfunction

  function automatic logic [2:0] exp_stop(input logic [7:0] l);
    if (!l[2]) return 3'h2;
    return (l[1:0] == 2'b00) ? 3'h3 : 3'h4;
  endfunction

  // Set enhanced enable through the divisor access window
  task automatic set_enh(input logic on);
    host.wr(3'h0, 32'h80, 4'h1);
    host.wr(3'h2, {27'h0, on, 4'h0}, 4'h1);
    host.wr(3'h0, 32'h0, 4'h1);
    chk("enh", enh_enable, on);
  endtask

  initial begin
    tick(3000);
    err_total++;
    finish_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'hbdf2d215));
    tick(8);
    rstn <= 1'b1;
    #1;
    chk("stat reset", int_status, 32'h01);
    chk("fifo reset", fifo_enable, 1'b0);
    host.rd(3'h0, d);
    chk("lfc reset", d, 32'h0);
    // Line format: random values plus all length codes
    for (int i = 0; i < 24; i++) begin
      lfc = (i < 4) ? {2'b01, 3'b011, 1'b1, i[1:0]} : 8'($urandom) & 8'h7f;
      host.wr(3'h0, {24'h0, lfc}, 4'h1);
      tick(1);
      #1;
      chk("tx_out", tx_out, !lfc[6]);
      chk("parity", parity_mode, exp_par(lfc));
      chk("bits", data_bits, 4'h5 + lfc[1:0]);
      chk("stop", stop_halves, exp_stop(lfc));
      host.rd(3'h0, d);
      chk("lfc read", d, {24'h0, lfc});
    end
    host.wr(3'h0, 32'h0, 4'h1);
    // Divisor behind the access bit, unmapped index
    host.wr(3'h0, 32'h80, 4'h1);
    host.wr(3'h1, 32'ha5c3, 4'h3);
    #1;
    chk("dlab", dlab, 1'b1);
    chk("divisor", divisor, 16'ha5c3);
    host.rd(3'h1, d);
    chk("div read", d, 32'ha5c3);
    host.wr(3'h0, 32'h0, 4'h1);
    host.rd(3'h5, d);
    chk("unmapped", d, 32'h0);
    // Fifo control: trigger codes, enable gating, receive clear
    for (int k = 0; k < 4; k++) begin
      host.wr(3'h1, {24'h0, k[1:0], 6'h01}, 4'h1);
      #1;
      chk("trigger", rx_trigger, trig_tab[k]);
      chk("fifo on", fifo_enable, 1'b1);
      chk("stat fifo", int_status[7:6], 2'b11);
    end
    host.wr(3'h1, 32'h42, 4'h1);
    #1;
    chk("fifo off", fifo_enable, 1'b0);
    chk("trig kept", rx_trigger, 5'h0e);
    chk("no clear", rx_fifo_clear, 1'b0);
    chk("stat nofifo", int_status[7:6], 2'b00);
    host.wr(3'h1, 32'hc3, 4'h1);
    #1;
    chk("clear hi", rx_fifo_clear, 1'b1);
    tick(1);
    #1;
    chk("clear lo", rx_fifo_clear, 1'b0);
    host.rd(3'h1, d);
    chk("fifo ctl read", d, 32'h0);
    // Receive threshold at trigger 14
    rx_count <= 5'd13;
    tick(2);
    #1;
    chk("below trig", int_status, 32'hc1);
    tick(1);
    rx_count <= 5'd14;
    tick(2);
    #1;
    chk("at trig", int_status, 32'hc4);
    tick(1);
    rx_count <= 5'd0;
    // Priority walk with every source pending
    host.wr(3'h1, 32'h01, 4'h1);
    set_enh(1'b1);
    ls_err <= 1;
    rx_count <= 5'd2;
    rx_timeout <= 1;
    thr_empty_set <= 1;
    modem_chg <= 1;
    xoff_match <= 1;
    flow_chg <= 1;
    tick(1);
    thr_empty_set <= 0;
    xoff_match <= 0;
    tick(2);
    for (int i = 0; i < 7; i++) begin
      host.rd(3'h2, d);
      chk("stat code", d, {24'h0, 2'b11, code_tab[i]});
      if (i != 3) begin
        host.rd(3'h2, d);
        chk("stat held", d[5:0], code_tab[i]);
      end
      case (i)
        0: ls_err <= 0;
        1: rx_count <= 5'd0;
        2: rx_timeout <= 0;
        4: modem_chg <= 0;
        5: xon_match <= 1;
        6: flow_chg <= 0;
        default: ;
      endcase
      tick(1);
      xon_match <= 0;
      tick(2);
    end
    #1;
    chk("stat idle", int_status, 32'hc1);
    // Enhanced sources silent without enhanced enable
    set_enh(1'b0);
    xoff_match <= 1;
    flow_chg <= 1;
    tick(1);
    xoff_match <= 0;
    tick(2);
    host.rd(3'h2, d);
    chk("stat noenh", d, 32'hc1);
    flow_chg <= 0;
    tx_in <= 1'b0;
    tick(2);
    #1;
    chk("tx pass", tx_out, 1'b0);
    // Holding empty set by an event, cleared by a load
    tick(1);
    thr_empty_set <= 1;
    tick(1);
    thr_empty_set <= 0;
    tick(2);
    #1;
    chk("thr set", int_status, 32'hc2);
    tick(1);
    thr_load <= 1;
    tick(1);
    thr_load <= 0;
    tick(2);
    #1;
    chk("thr load", int_status, 32'hc1);
    finish_test();
  end
endmodule // ufc_ctrl_test
